// >>> rtl/lpx_extractor.sv
// Laser peak profile extractor: timing, compression, peak search and fit
// Contract
// - Effective exposure is clamped to profile period minus three microseconds.
// - A sample is a peak candidate only when it passes the threshold.
// - A column with no qualifying peak reports range value zero.
// - Normal direction reports the first qualifying peak scanning top down.
// - Reverse direction reports the last qualifying peak.
// - Direction only matters in first-local mode, except equal-maximum ties in strongest mode.
// - Samples at or below threshold never take part in peak selection.
// - Strongest mode picks the maximum intensity sample of the column.
// - First-local mode picks the first local maximum along scan direction.
// - Saturated strongest-mode plateaus lean toward the scan's first peak.
// - Peak position is refined by centroid over rows around the maximum.
// - Fit window is 7, 15 or 31 rows for small, normal, large.
// - Compression maps intensity through two linear segments joined at a knee.
// - Compression offers off plus three presets of about 2x, 6x, 15x range.
// - Compression is enabled after reset.
// - Compressed mode waits for readout to finish before next exposure.
// - Linear mode lets the next exposure overlap the previous readout.
// - Internal period paces capture only without external trigger.
// - Exposure and period limits are exact integer microseconds.
// - Fitted position has at most sixteen fractional levels per row.
// - Region height is a multiple of four rows, width of sixteen columns.
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module lpx_extractor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trig_i,
  input wire logic pix_valid_i,
  input wire logic [11:0] pix_data_i,
  output logic pix_ready_o,
  output logic expose_o,
  output logic readout_o,
  output logic range_valid_o,
  output lpx_pkg::lpx_range_s range_o,
  output logic profile_done_o
);
  import lpx_pkg::*;

  typedef enum logic [1:0] {S_CAPT = 2'b00, S_FIT = 2'b01, S_DIV = 2'b10, S_OUT = 2'b11} lpx_st_e;

  // Two-segment response with knee and reduced upper slope
  function automatic logic [7:0] compress(input logic [11:0] v, input lpx_comp_e m);
    logic [11:0] knee;
    logic [11:0] y;
    knee = KNEE_LIGHT;
    y = v;
    unique case (m)
      COMP_OFF: y = v;
      COMP_LIGHT: knee = KNEE_LIGHT;
      COMP_MODERATE: knee = KNEE_MODERATE;
      COMP_STRONG: knee = KNEE_STRONG;
    endcase
    if (m != COMP_OFF && v > knee)
    begin
      unique case (m)
        COMP_LIGHT: y = knee + ((v - knee) >> SHIFT_LIGHT);
        COMP_MODERATE: y = knee + ((v - knee) >> SHIFT_MODERATE);
        default: y = knee + ((v - knee) >> SHIFT_STRONG);
      endcase
    end
    return (y > 12'h0ff) ? 8'hff : y[7:0];
  endfunction : compress

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  // Registers
  lpx_cfg_s cfg_q;
  logic [7:0] thr_q;
  logic [15:0] exp_q, per_q, ro_q;
  logic [11:0] width_q;
  logic [6:0] height_q;
  logic [15:0] prof_cnt_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] wval;
  logic [15:0] exp_eff;
  logic wr_en;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

  // Exposure limited by period minus readout/reset guard
  always_comb
  begin
    exp_eff = exp_q; // integer microseconds, exact
    if (per_q <= GUARD_US)
      exp_eff = 16'h0001;
    else if (exp_q > per_q - GUARD_US)
      exp_eff = per_q - GUARD_US;
    if (exp_eff == 16'h0000)
      exp_eff = 16'h0001;
  end

  // Register writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q <= CFG_RST;
      thr_q <= THRESH_RST;
      exp_q <= EXPOSE_RST;
      per_q <= PERIOD_RST;
      ro_q <= READOUT_RST;
      width_q <= WIDTH_RST;
      height_q <= ROWS_MAX_W;
    end
    else if (wr_en)
    begin
      unique case (wb_adr_i)
        ADR_CTRL: cfg_q <= lpx_cfg_s'(wval[7:0]);
        ADR_THRESH: thr_q <= wval[7:0];
        ADR_EXPOSE: exp_q <= wval[15:0];
        ADR_PERIOD: per_q <= wval[15:0];
        ADR_READOUT: ro_q <= wval[15:0];
        ADR_REGION:
        begin
          // alignment and limits of the region
          width_q <= (wval[11:0] < COLS_MIN) ? COLS_MIN : (wval[11:0] & COL_ALIGN_MASK);
          if (wval[31:16] > 16'(ROWS_MAX_W))
            height_q <= ROWS_MAX_W;
          else if (wval[22:16] < ROWS_MIN)
            height_q <= ROWS_MIN;
          else
            height_q <= wval[22:16] & ROW_ALIGN_MASK;
        end
        default: ;
      endcase
    end
  end

  // Current register value under the write, merged per byte lane
  always_comb
  begin
    unique case (wb_adr_i)
      ADR_CTRL: wval = merge({24'h000000, cfg_q}, wb_dat_i, wb_sel_i);
      ADR_THRESH: wval = merge({24'h000000, thr_q}, wb_dat_i, wb_sel_i);
      ADR_EXPOSE: wval = merge({16'h0000, exp_q}, wb_dat_i, wb_sel_i);
      ADR_PERIOD: wval = merge({16'h0000, per_q}, wb_dat_i, wb_sel_i);
      ADR_READOUT: wval = merge({16'h0000, ro_q}, wb_dat_i, wb_sel_i);
      ADR_REGION: wval = merge({9'h000, height_q, 4'h0, width_q}, wb_dat_i, wb_sel_i);
      default: wval = 32'h00000000;
    endcase
  end

  // Wishbone answer one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      unique case (wb_adr_i)
        ADR_CTRL: rdat_q <= {24'h000000, cfg_q};
        ADR_THRESH: rdat_q <= {24'h000000, thr_q};
        ADR_EXPOSE: rdat_q <= {16'h0000, exp_q};
        ADR_PERIOD: rdat_q <= {16'h0000, per_q};
        ADR_READOUT: rdat_q <= {16'h0000, ro_q};
        ADR_REGION: rdat_q <= {9'h000, height_q, 4'h0, width_q};
        ADR_STATUS: rdat_q <= {13'h0000, !pix_ready_o, readout_o, expose_o, prof_cnt_q};
        ADR_EXP_EFF: rdat_q <= {16'h0000, exp_eff};
        default: rdat_q <= 32'h00000000;
      endcase
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Trigger pin synchroniser and edge detect
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      {trig_s1_q, trig_s2_q, trig_s3_q} <= 3'b000;
    else
      {trig_s1_q, trig_s2_q, trig_s3_q} <= {trig_i, trig_s1_q, trig_s2_q};
  end

  // Microsecond tick
  logic [7:0] tick_cnt_q;
  logic us_tick;
  assign us_tick = (tick_cnt_q == US_TICK_LAST);
  always_ff @(posedge clk_i)
  begin
    if (rst_i || us_tick)
      tick_cnt_q <= 8'h00;
    else
      tick_cnt_q <= tick_cnt_q + 8'h01;
  end

  // Exposure and readout sequencer
  logic [15:0] per_cnt_q, exp_cnt_q, ro_cnt_q;
  logic expose_q, readout_q, start;
  always_comb
  begin
    start = cfg_q.enable && !expose_q;
    if (cfg_q.ext_trig)
      start = start && trig_s2_q && !trig_s3_q;
    else
      start = start && (per_cnt_q >= per_q);
    if (cfg_q.compression_select != COMP_OFF)
      start = start && !readout_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      expose_q <= 1'b0;
      readout_q <= 1'b0;
      per_cnt_q <= 16'h0000;
      exp_cnt_q <= 16'h0000;
      ro_cnt_q <= 16'h0000;
    end
    else
    begin
      if (start)
      begin
        expose_q <= 1'b1;
        exp_cnt_q <= 16'h0000;
        per_cnt_q <= 16'h0000;
      end
      else if (us_tick && per_cnt_q != 16'hffff)
        per_cnt_q <= per_cnt_q + 16'h0001;
      if (expose_q && us_tick)
      begin
        if (exp_cnt_q + 16'h0001 >= exp_eff)
        begin
          expose_q <= 1'b0;
          readout_q <= 1'b1; // may run under the next exposure
          ro_cnt_q <= 16'h0000;
        end
        else
          exp_cnt_q <= exp_cnt_q + 16'h0001;
      end
      if (readout_q && us_tick && !(expose_q && exp_cnt_q + 16'h0001 >= exp_eff))
      begin
        if (ro_cnt_q + 16'h0001 >= ro_q)
          readout_q <= 1'b0;
        else
          ro_cnt_q <= ro_cnt_q + 16'h0001;
      end
    end
  end
  assign expose_o = expose_q;
  assign readout_o = readout_q;

  // Column capture and peak search
  lpx_st_e st_q;
  logic [7:0] col_mem_q [ROWS_MAX];
  logic [5:0] row_q, pk_row_q, k_q;
  logic [7:0] prev_q, best_q, c;
  logic rise_q, found_q, rdy_q, acc, last, abv, loc, endc;
  logic [5:0] last_row;
  assign c = compress(pix_data_i, cfg_q.compression_select);
  assign acc = (st_q == S_CAPT) && rdy_q && pix_valid_i;
  assign last_row = 6'(height_q - 7'h01);
  assign last = (row_q == last_row);
  assign abv = (c > thr_q);
  // Local maximum just passed at previous row, or still rising at the end
  assign loc = (row_q != 6'h00) && (prev_q > thr_q) && rise_q && (c < prev_q);
  assign endc = last && abv && ((row_q == 6'h00) || c > prev_q || (c == prev_q && rise_q));

  // Sample storage
  always_ff @(posedge clk_i)
  begin
    if (acc)
      col_mem_q[row_q] <= c;
  end

  // Peak tracking per column
  always_ff @(posedge clk_i)
  begin
    if (rst_i || st_q == S_OUT)
    begin
      prev_q <= 8'h00;
      rise_q <= 1'b1;
      found_q <= 1'b0;
      best_q <= 8'h00;
      pk_row_q <= 6'h00;
    end
    else if (acc)
    begin
      prev_q <= c;
      rise_q <= (c > prev_q) || (c == prev_q && rise_q);
      if (!cfg_q.first_above_threshold_search)
      begin
        // maximum; reverse lets equal later samples win
        if (abv && (!found_q || c > best_q || (cfg_q.reverse && c == best_q)))
        begin
          found_q <= 1'b1;
          best_q <= c;
          pk_row_q <= row_q;
        end
      end
      else if (!cfg_q.reverse)
      begin
        if (!found_q && (loc || endc))
        begin
          found_q <= 1'b1;
          pk_row_q <= loc ? row_q - 6'h01 : row_q;
        end
      end
      else if (loc || endc) // keep the latest
      begin
        found_q <= 1'b1;
        pk_row_q <= endc ? row_q : row_q - 6'h01;
      end
    end
  end

  // Window bounds around the selected row
  logic [4:0] half;
  logic [6:0] hi_sum;
  logic [5:0] w_lo, w_hi;
  logic [7:0] wgt;
  always_comb
  begin
    unique case (cfg_q.peak_fit_window)
      WIN_SMALL: half = WIN_HALF_SMALL;
      WIN_LARGE: half = WIN_HALF_LARGE;
      default: half = WIN_HALF_NORMAL;
    endcase
    w_lo = (pk_row_q > 6'(half)) ? pk_row_q - 6'(half) : 6'h00;
    hi_sum = {1'b0, pk_row_q} + {2'b00, half};
    w_hi = (hi_sum > {1'b0, last_row}) ? last_row : hi_sum[5:0];
    wgt = (col_mem_q[k_q] > thr_q) ? col_mem_q[k_q] - thr_q : 8'h00;
  end

  // Fit, divide and output sequencer
  logic [13:0] sum_w_q;
  logic [18:0] sum_wr_q;
  logic [22:0] num_q;
  logic [14:0] rem_q;
  logic [14:0] rem_sh;
  logic [4:0] div_cnt_q;
  logic [11:0] col_q;
  logic vld_q, done_q;
  lpx_range_s rng_q;
  assign rem_sh = {rem_q[13:0], num_q[22]};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= S_CAPT;
      rdy_q <= 1'b1;
      row_q <= 6'h00;
      k_q <= 6'h00;
      sum_w_q <= 14'h0000;
      sum_wr_q <= 19'h00000;
      num_q <= 23'h000000;
      rem_q <= 15'h0000;
      div_cnt_q <= 5'h00;
    end
    else
    begin
      unique case (st_q)
        S_CAPT:
          if (acc)
          begin
            row_q <= last ? 6'h00 : row_q + 6'h01;
            if (last)
            begin
              rdy_q <= 1'b0;
              st_q <= S_FIT;
              k_q <= 6'h00;
              sum_w_q <= 14'h0000;
              sum_wr_q <= 19'h00000;
            end
          end
        S_FIT:
          if (!found_q)
            st_q <= S_OUT;
          else
          begin
            if (k_q >= w_lo)
            begin
              sum_w_q <= sum_w_q + 14'(wgt);
              sum_wr_q <= sum_wr_q + 19'(wgt * k_q);
            end
            if (k_q == w_hi)
            begin
              st_q <= S_DIV;
              num_q <= 23'(sum_wr_q + ((k_q >= w_lo) ? 19'(wgt * k_q) : 19'h00000))
                       << FRAC_BITS;
              sum_w_q <= sum_w_q + ((k_q >= w_lo) ? 14'(wgt) : 14'h0000);
              rem_q <= 15'h0000;
              div_cnt_q <= 5'h00;
            end
            else
              k_q <= k_q + 6'h01;
          end
        S_DIV:
        begin
          // Restoring division, one quotient bit per cycle
          if (rem_sh >= {1'b0, sum_w_q})
          begin
            rem_q <= rem_sh - {1'b0, sum_w_q};
            num_q <= {num_q[21:0], 1'b1};
          end
          else
          begin
            rem_q <= rem_sh;
            num_q <= {num_q[21:0], 1'b0};
          end
          div_cnt_q <= div_cnt_q + 5'h01;
          if (div_cnt_q == 5'(DIV_STEPS - 1))
            st_q <= S_OUT;
        end
        S_OUT:
        begin
          st_q <= S_CAPT;
          rdy_q <= 1'b1;
        end
      endcase
    end
  end
  assign pix_ready_o = rdy_q;

  // Result publication, one per column
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vld_q <= 1'b0;
      done_q <= 1'b0;
      col_q <= 12'h000;
      rng_q <= '0;
      prof_cnt_q <= 16'h0000;
    end
    else
    begin
      vld_q <= (st_q == S_OUT);
      done_q <= 1'b0;
      if (st_q == S_OUT)
      begin
        rng_q.col <= col_q;
        rng_q.value <= found_q ? num_q[15:0] + RANGE_ROW_BIAS : RANGE_MISSING;
        if (col_q + 12'h001 >= width_q)
        begin
          col_q <= 12'h000;
          done_q <= 1'b1;
          prof_cnt_q <= prof_cnt_q + 16'h0001;
        end
        else
          col_q <= col_q + 12'h001;
      end
    end
  end
  assign range_valid_o = vld_q;
  assign range_o = rng_q;
  assign profile_done_o = done_q;
endmodule : lpx_extractor

// >>> rtl/lpx_pkg.sv
// Package with constants, types and register map for the laser peak extractor
package lpx_pkg;
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CYC_PER_US = 1000 / CLK_PERIOD_NS;
  localparam logic [15:0] GUARD_US = 16'h0003;
  localparam logic [7:0] US_TICK_LAST = 8'(CYC_PER_US - 1);
  // Geometry
  localparam int unsigned ROWS_MAX = 64;
  localparam logic [6:0] ROWS_MAX_W = 7'h40;
  localparam logic [6:0] ROWS_MIN = 7'h04;
  localparam logic [11:0] COLS_MIN = 12'h010;
  localparam logic [6:0] ROW_ALIGN_MASK = 7'h7c;
  localparam logic [11:0] COL_ALIGN_MASK = 12'hff0;
  localparam logic [15:0] RANGE_MISSING = 16'h0000;
  localparam logic [15:0] RANGE_ROW_BIAS = 16'h0010;
  localparam int unsigned FRAC_BITS = 4;
  localparam int unsigned DIV_STEPS = 23;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_THRESH = 8'h04;
  localparam logic [7:0] ADR_EXPOSE = 8'h08;
  localparam logic [7:0] ADR_PERIOD = 8'h0c;
  localparam logic [7:0] ADR_READOUT = 8'h10;
  localparam logic [7:0] ADR_REGION = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  localparam logic [7:0] ADR_EXP_EFF = 8'h1c;
  // Reset values
  localparam logic [7:0] THRESH_RST = 8'h14;
  localparam logic [15:0] EXPOSE_RST = 16'h0064;
  localparam logic [15:0] PERIOD_RST = 16'h0100;
  localparam logic [15:0] READOUT_RST = 16'h0021;
  localparam logic [11:0] WIDTH_RST = 12'h100;
  // Window selection and compression presets
  typedef enum logic [1:0] {WIN_SMALL = 2'b00, WIN_NORMAL = 2'b01, WIN_LARGE = 2'b10} lpx_win_e;
  typedef enum logic [1:0] {
    COMP_OFF = 2'b00, COMP_LIGHT = 2'b01, COMP_MODERATE = 2'b10, COMP_STRONG = 2'b11
  } lpx_comp_e;
  localparam logic [4:0] WIN_HALF_SMALL = 5'd3;
  localparam logic [4:0] WIN_HALF_NORMAL = 5'd7;
  localparam logic [4:0] WIN_HALF_LARGE = 5'd15;
  localparam logic [11:0] KNEE_LIGHT = 12'h080;
  localparam logic [11:0] KNEE_MODERATE = 12'h0a0;
  localparam logic [11:0] KNEE_STRONG = 12'h0c0;
  localparam int unsigned SHIFT_LIGHT = 2;
  localparam int unsigned SHIFT_MODERATE = 4;
  localparam int unsigned SHIFT_STRONG = 6;
  // Control register layout, high bits first
  typedef struct packed {
    logic ext_trig;
    lpx_comp_e compression_select;
    lpx_win_e peak_fit_window;
    logic reverse;
    logic first_above_threshold_search;
    logic enable;
  } lpx_cfg_s;
  localparam lpx_cfg_s CFG_RST = '{1'b0, COMP_MODERATE, WIN_NORMAL, 1'b0, 1'b0, 1'b0};
  // One range result
  typedef struct packed {
    logic [11:0] col;
    logic [15:0] value;
  } lpx_range_s;
endpackage : lpx_pkg

// >>> tb/lpx_extractor_monitor.sv
// Port checker for the laser peak extractor
`timescale 1ns/1ps
module lpx_extractor_monitor
  import lpx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic trig_i,
  input wire logic expose_o,
  input wire logic readout_o,
  input wire logic range_valid_o,
  input wire lpx_pkg::lpx_range_s range_o,
  input wire logic profile_done_o
);
  logic req, trig_q;
  lpx_cfg_s ctrl_q;
  logic [15:0] per_q;
  int exp_cnt_q, trig_age_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Shadow copies of control and period
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CFG_RST;
      per_q <= PERIOD_RST;
    end
    else if (req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == ADR_CTRL)
        ctrl_q <= lpx_cfg_s'(wb_dat_i[7:0]);
      if (wb_adr_i == ADR_PERIOD)
        per_q <= wb_dat_i[15:0];
    end
  end
  // Exposure length and cycles since trigger edge
  always_ff @(posedge clk_i)
  begin
    trig_q <= trig_i;
    exp_cnt_q <= expose_o ? exp_cnt_q + 1 : 0;
    if (rst_i)
      trig_age_q <= 1000;
    else if (trig_i && !trig_q)
      trig_age_q <= 0;
    else if (trig_age_q < 1000)
      trig_age_q <= trig_age_q + 1;
  end
  property p_ack_next; req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_unmapped; req && !wb_we_i && wb_adr_i >= 8'h20 |=> wb_dat_o == 32'h0; endproperty
  property p_done; profile_done_o |-> range_valid_o; endproperty
  property p_hold; !range_valid_o |-> $stable(range_o); endproperty
  property p_nonzero;
    range_valid_o && range_o.value != RANGE_MISSING |-> range_o.value >= RANGE_ROW_BIAS;
  endproperty
  property p_no_overlap;
    ctrl_q.compression_select != COMP_OFF |-> !(expose_o && readout_o);
  endproperty
  property p_exp_limit;
    expose_o |-> exp_cnt_q < (int'(per_q) - int'(GUARD_US)) * int'(CYC_PER_US);
  endproperty
  property p_trig_start; ctrl_q.ext_trig && $rose(expose_o) |-> trig_age_q < 16; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_done: assert property (p_done) else $error("done without result");
  a_hold: assert property (p_hold) else $error("result changed without valid");
  a_nonzero: assert property (p_nonzero) else $error("peak code below row bias");
  a_no_overlap: assert property (p_no_overlap) else $error("overlap in compressed mode");
  a_exp_limit: assert property (p_exp_limit) else $error("exposure exceeds period limit");
  a_trig_start: assert property (p_trig_start) else $error("exposure without trigger");
  c_missing: cover property (range_valid_o && range_o.value == RANGE_MISSING);
  c_done: cover property (profile_done_o);
  c_overlap: cover property (expose_o && readout_o);
  c_trig: cover property (ctrl_q.ext_trig && $rose(expose_o));
endmodule : lpx_extractor_monitor

bind lpx_extractor lpx_extractor_monitor i_mon (.*);

// >>> tb/lpx_pixel_source.sv
// Sensor column source model
`timescale 1ns/1ps
module lpx_pixel_source (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic stall_i,
  input wire logic [6:0] rows_i,
  input wire logic [767:0] col_i,
  input wire logic pix_ready_i,
  output logic pix_valid_o,
  output logic [11:0] pix_data_o
);
  logic busy_q, last_row, last;
  logic [6:0] row_q, nrow;
  logic [3:0] col_q;
  assign last_row = row_q == rows_i - 7'h01;
  assign last = last_row && col_q == 4'hf;
  assign nrow = last_row ? 7'h00 : row_q + 7'h01;
  // Rows top down, data scrambled whenever not valid
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
      pix_valid_o <= 1'b0;
      pix_data_o <= 12'h000;
    end
    else if (go_i && !busy_q)
    begin
      busy_q <= 1'b1;
      row_q <= 7'h00;
      col_q <= 4'h0;
      pix_valid_o <= 1'b1;
      pix_data_o <= col_i[11:0];
    end
    else if (busy_q && pix_valid_o && pix_ready_i)
    begin
      busy_q <= !last;
      row_q <= nrow;
      col_q <= col_q + 4'(last_row);
      pix_valid_o <= !stall_i && !last;
      pix_data_o <= (stall_i || last) ? ~pix_data_o : col_i[12 * nrow +: 12];
    end
    else if (busy_q && !pix_valid_o)
    begin
      pix_valid_o <= 1'b1;
      pix_data_o <= col_i[12 * row_q +: 12];
    end
    else if (!busy_q)
      pix_data_o <= ~pix_data_o;
  end
endmodule : lpx_pixel_source

// >>> tb/testbench.sv
// Self-checking bench for the laser peak extractor
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  import lpx_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic trig = 1'b0, go = 1'b0, stall = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0, wb_rdat;
  logic [6:0] rows = 7'h08;
  logic [767:0] col = '0;
  logic [11:0] pix_data;
  logic wb_ack, pix_valid, pix_ready, expose, readout, range_valid, done;
  lpx_range_s res;
  int n_fail = 0, checks_done = 0, cyc_cnt = 0;
  lpx_extractor i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .trig_i(trig), .pix_valid_i(pix_valid),
    .pix_data_i(pix_data), .pix_ready_o(pix_ready), .expose_o(expose), .readout_o(readout),
    .range_valid_o(range_valid), .range_o(res), .profile_done_o(done));
  lpx_pixel_source i_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .stall_i(stall),
    .rows_i(rows), .col_i(col), .pix_ready_i(pix_ready), .pix_valid_o(pix_valid),
    .pix_data_o(pix_data));
  // Clock and hang guard
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 80000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Classic single Wishbone cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    @(posedge clk_i);
    while (wb_ack !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    if (wb_ack !== 1'b1)
      n_fail++;
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic setc(input logic fl, input logic rev, input lpx_win_e w,
                      input lpx_comp_e cm, input logic ext, input logic en);
    lpx_cfg_s c;
    c = '{ext, cm, w, rev, fl, en};
    wr(ADR_CTRL, 32'(c));
  endtask : setc
  function automatic logic [767:0] pk3(input int a, va, b, vb, c, vc);
    pk3 = '0;
    pk3[12 * a +: 12] = 12'(va);
    pk3[12 * b +: 12] = 12'(vb);
    pk3[12 * c +: 12] = 12'(vc);
  endfunction : pk3
  // One profile of sixteen identical columns, every result judged
  task automatic profile(input logic [767:0] v, input logic [6:0] r, input logic [15:0] ev,
                         input logic s);
    int c;
    int n;
    c = 0;
    n = 0;
    col <= v;
    rows <= r;
    stall <= s;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    while (c < 16 && n < 9000)
    begin
      @(posedge clk_i);
      n++;
      if (range_valid === 1'b1)
      begin
        `CHK(res, {12'(c), ev})
        `CHK(done, 1'(c == 15))
        c++;
      end
    end
    `CHK(c, 16)
  endtask : profile
  // Wait for a rising exposure within a limit
  task automatic rise(input int lim, output int n);
    n = 0;
    while (expose !== 1'b0 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    while (expose !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : rise
  task automatic idle();
    int n;
    setc(1'b0, 1'b0, WIN_NORMAL, COMP_OFF, 1'b0, 1'b0);
    n = 0;
    while ((expose !== 1'b0 || readout !== 1'b0) && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : idle
  // Reset values, unmapped place, detection and missing data
  task automatic t_basic();
    logic [31:0] q;
    bus(1'b0, ADR_CTRL, 32'h0, q);
    `CHK(q, 32'h0000_0048)
    bus(1'b0, ADR_EXP_EFF, 32'h0, q);
    `CHK(q, 32'h0000_0064)
    wr(8'h40, 32'hffff_ffff);
    bus(1'b0, 8'h40, 32'h0, q);
    `CHK(q, 32'h0)
    wr(ADR_REGION, 32'h0008_0010);
    setc(1'b0, 1'b0, WIN_SMALL, COMP_OFF, 1'b0, 1'b0);
    profile(pk3(4, 40, 5, 100, 6, 40), 7'd8, 16'd96, 1'b0);
    profile({64{12'd20}}, 7'd8, RANGE_MISSING, 1'b0);
  endtask : t_basic
  // Every compression preset against three strict thresholds
  task automatic t_comp();
    int tv[3] = '{190, 200, 250};
    logic [11:0] hit = 12'h21f;
    for (int m = 0; m < 4; m++)
      for (int t = 0; t < 3; t++)
      begin
        wr(ADR_THRESH, 32'(tv[t]));
        setc(1'b0, 1'b0, WIN_SMALL, lpx_comp_e'(m), 1'b0, 1'b0);
        profile(pk3(5, 600, 0, 0, 0, 0), 7'd8, hit[m*3+t] ? 16'd96 : 16'd0, 1'b0);
      end
    wr(ADR_THRESH, 32'h14);
  endtask : t_comp
  // Search modes, directions and a saturated plateau
  task automatic t_search();
    logic [767:0] v;
    logic [767:0] p;
    v = pk3(2, 30, 3, 60, 4, 30) | pk3(9, 30, 10, 100, 11, 30);
    p = pk3(5, 4095, 6, 4095, 7, 4095) | pk3(8, 4095, 9, 4095, 63, 0);
    wr(ADR_REGION, 32'h0020_0010);
    setc(1'b0, 1'b0, WIN_SMALL, COMP_OFF, 1'b0, 1'b0);
    profile(v, 7'd32, 16'd176, 1'b1);
    profile(p, 7'd32, 16'd120, 1'b0);
    setc(1'b0, 1'b1, WIN_SMALL, COMP_OFF, 1'b0, 1'b0);
    profile(v, 7'd32, 16'd176, 1'b0);
    profile(p, 7'd32, 16'd136, 1'b0);
    setc(1'b1, 1'b0, WIN_SMALL, COMP_OFF, 1'b0, 1'b0);
    profile(v, 7'd32, 16'd64, 1'b0);
    setc(1'b1, 1'b1, WIN_SMALL, COMP_OFF, 1'b0, 1'b0);
    profile(v, 7'd32, 16'd176, 1'b0);
  endtask : t_search
  // Three fit windows on an unaligned region request
  task automatic t_window();
    logic [15:0] ev [3] = '{16'd144, 16'd170, 16'd212};
    wr(ADR_REGION, 32'h0023_0011);
    for (int w = 0; w < 3; w++)
    begin
      setc(1'b0, 1'b0, lpx_win_e'(w), COMP_OFF, 1'b0, 1'b0);
      profile(pk3(8, 100, 13, 60, 20, 60), 7'd32, ev[w], 1'b0);
    end
  endtask : t_window
  // Exposure clamp, readout overlap and triggering
  task automatic t_timing();
    logic [31:0] q;
    int n;
    int ov;
    wr(ADR_PERIOD, 32'd10);
    wr(ADR_EXPOSE, 32'd20);
    wr(ADR_READOUT, 32'd4);
    bus(1'b0, ADR_EXP_EFF, 32'h0, q);
    `CHK(q, 32'd7)
    setc(1'b0, 1'b0, WIN_NORMAL, COMP_OFF, 1'b0, 1'b1);
    rise(5000, n);
    rise(5000, n);
    n = 0;
    while (expose === 1'b1 && n < 5000)
    begin
      @(posedge clk_i);
      n++;
    end
    `CHK(1'(n >= 1398 && n <= 1402), 1'b1)
    ov = 0;
    repeat (1000)
    begin
      @(posedge clk_i);
      if (expose === 1'b1 && readout === 1'b1)
        ov = 1;
    end
    `CHK(ov, 1)
    idle();
    setc(1'b0, 1'b0, WIN_NORMAL, COMP_MODERATE, 1'b0, 1'b1);
    rise(5000, n);
    rise(5000, n);
    `CHK(1'(n > 2190 && n < 5000), 1'b1)
    idle();
    setc(1'b0, 1'b0, WIN_NORMAL, COMP_OFF, 1'b1, 1'b1);
    rise(2500, n);
    `CHK(n, 2500)
    trig <= 1'b1;
    rise(40, n);
    `CHK(1'(n < 40), 1'b1)
    trig <= 1'b0;
  endtask : t_timing
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_basic();
    t_comp();
    t_search();
    t_window();
    t_timing();
    give_verdict();
  end
endmodule : testbench
